// >>> ipvc_cfg.svh
// Constants of the interrupt priority and vector configuration block.
// Assumes the includer imports nothing else under these macro names.
// Operation
// R1 - A 2-bit priority field of 00 disables its source, 01 gives level 0, 10 level 1, 11 level 2.
// R2 - Every priority field resets to 00, so all these sources start disabled.
// R3 - Only levels 0 to 2 exist for these sources; no code gives a higher level.
// R4 - The first priority register holds serial-0 and timer-A channel fields at fixed positions.
// R5 - The second priority register holds PWM and ADC fields at fixed positions.
// R6 - Reserved bits of these registers read as zero and ignore writes.
// R7 - The 13-bit vector base field forms the upper 13 bits of the 21-bit vector address.
// R8 - The lower eight address bits come from the winning source and sit below the base.
// R9 - The 7-bit fast selector names the vector number that becomes fast interrupt 0.
// R10 - A winning fast source drives its programmed fast address instead of the table address.
// R11 - Software sets any fast-selected source to level 2, otherwise behaviour is undefined.
// R12 - A fast-selected source outranks every other level-2 source.
// R13 - When both fast selections are pending, fast interrupt 0 wins over fast interrupt 1.
// R14 - Each fast vector address is 21 bits, a 16-bit low part and a 5-bit high part.
// R15 - Only pending enabled sources request; highest level wins, lower vector number breaks ties.
`ifndef IPVC_CFG_SVH
`define IPVC_CFG_SVH

`define IPVC_IDX_PRI0 8'h08
`define IPVC_IDX_PRI1 8'h09
`define IPVC_IDX_BASE 8'h0A
`define IPVC_IDX_FAST0 8'h0B
`define IPVC_IDX_STAT 8'h20

`define IPVC_MASK_PRI0 16'hF3FF
`define IPVC_MASK_PRI1 16'hFFFF
`define IPVC_MASK_BASE 16'h1FFF
`define IPVC_MASK_FAST0 16'h007F
`define IPVC_RST_REG 16'h0000

`define IPVC_POS_S0_RX_FULL 14
`define IPVC_POS_S0_RX_ERR 12
`define IPVC_POS_S0_TX_IDLE 8
`define IPVC_POS_S0_TX_EMPTY 6
`define IPVC_POS_TA_CH3 4
`define IPVC_POS_TA_CH2 2
`define IPVC_POS_TA_CH1 0
`define IPVC_POS_PWMA_FAULT 14
`define IPVC_POS_PWMB_FAULT 12
`define IPVC_POS_PWMA_RELOAD 10
`define IPVC_POS_PWMB_RELOAD 8
`define IPVC_POS_ADCA_ZC 6
`define IPVC_POS_ADCB_ZC 4
`define IPVC_POS_ADCA_DONE 2
`define IPVC_POS_ADCB_DONE 0

`define IPVC_FLD_OFF 2'h0
`define IPVC_FLD_LVL2 2'h3
`define IPVC_LVL_TOP 2'h2
`define IPVC_SRC_COUNT 15
`define IPVC_VEC_FIRST 7'h40
`define IPVC_HSIZE_WORD 3'h2

`endif

// >>> ipvc_pkg.sv
// Types shared by the interrupt priority and vector configuration block.
// Assumes ipvc_cfg.svh supplies the numeric constants.
package ipvc_pkg;
    typedef logic [1:0] ipvc_field_type;
    typedef logic [6:0] ipvc_vecnum_type;
    typedef logic [20:0] ipvc_addr_type;
    typedef logic [15:0] ipvc_reg_type;
endpackage

// >>> ipvc_level_decode.sv
// Decodes one 2-bit priority field into an enable and a level.
// Assumes the field comes from a register on the same clock.
`timescale 1ns/1ps
`include "ipvc_cfg.svh"
module ipvc_level_decode (
    // Priority field
    input wire ipvc_pkg::ipvc_field_type field,
    // Decoded result
    output logic enabled,
    output logic [1:0] level
);
    import ipvc_pkg::*;

    assign enabled = (field != `IPVC_FLD_OFF); // R1
    // Code 11 maps to level 2, so no code reaches a level above it.
    assign level = enabled ? (field - 2'h1) : 2'h0; // R3
endmodule

// >>> ipvc_vector_select.sv
// Picks the winning interrupt source among pending, enabled sources.
// Assumes all inputs are synchronous to the caller's clock.
`timescale 1ns/1ps
`include "ipvc_cfg.svh"
module ipvc_vector_select #(
    parameter int SRC_N = `IPVC_SRC_COUNT,
    parameter logic [6:0] VEC_FIRST = `IPVC_VEC_FIRST
) (
    // Sources
    input wire logic [SRC_N-1:0] pending,
    input wire logic [SRC_N-1:0] enabled,
    input wire logic [1:0] level [SRC_N],
    // Fast selections
    input wire ipvc_pkg::ipvc_vecnum_type fastSel0,
    input wire ipvc_pkg::ipvc_vecnum_type fastSel1,
    // Winner
    output logic found,
    output ipvc_pkg::ipvc_vecnum_type winVec,
    output logic [1:0] winLevel,
    output logic winFast0,
    output logic winFast1,
    output logic fast0Live,
    output logic fast1Live
);
    import ipvc_pkg::*;

    logic [4:0] rank;
    logic [4:0] bestRank;
    logic [6:0] vec;
    logic isF0;
    logic isF1;

    // A fast bonus counts only at level 2; at any other level it is ignored.
    always_comb begin
        rank = 5'h00;
        bestRank = 5'h00;
        vec = 7'h00;
        isF0 = 1'b0;
        isF1 = 1'b0;
        found = 1'b0;
        winVec = 7'h00;
        winLevel = 2'h0;
        winFast0 = 1'b0;
        winFast1 = 1'b0;
        fast0Live = 1'b0;
        fast1Live = 1'b0;
        for (int i = 0; i < SRC_N; i++) begin
            vec = VEC_FIRST + 7'(i);
            isF0 = (vec == fastSel0) && (level[i] == `IPVC_LVL_TOP); // R9
            isF1 = (vec == fastSel1) && (level[i] == `IPVC_LVL_TOP);
            rank = {isF0, isF1, 1'b1, level[i]}; // R12 R13
            if (pending[i] && enabled[i]) begin
                fast0Live = fast0Live | isF0;
                fast1Live = fast1Live | isF1;
            end
            // Strict compare keeps the lower vector number on a tie.
            if (pending[i] && enabled[i] && (rank > bestRank)) begin // R15
                bestRank = rank;
                found = 1'b1;
                winVec = vec;
                winLevel = level[i];
                winFast0 = isF0;
                winFast1 = isF1 && !isF0;
            end
        end
    end
endmodule

// >>> ipvc_config.sv
// Priority registers, vector base, fast selector and vector address output.
// Assumes one AHB-Lite master, pending inputs on ref_clk, and a core that
// samples the registered vector outputs.
`timescale 1ns/1ps
`include "ipvc_cfg.svh"
module ipvc_config #(
    parameter int SRC_N = `IPVC_SRC_COUNT,
    parameter logic [6:0] VEC_FIRST = `IPVC_VEC_FIRST
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Interrupt sources
    input wire logic [SRC_N-1:0] srcPending,
    // Fast interrupt 1 selection and both fast vector addresses
    input wire ipvc_pkg::ipvc_vecnum_type fastIrq1Select,
    input wire logic [15:0] fast0VectorLow,
    input wire logic [4:0] fast0VectorHigh,
    input wire logic [15:0] fast1VectorLow,
    input wire logic [4:0] fast1VectorHigh,
    // To the core
    output logic irqRequest,
    output logic [1:0] irqLevel,
    output logic irqFast,
    output ipvc_pkg::ipvc_vecnum_type irqVector,
    output ipvc_pkg::ipvc_addr_type vectorAddressBus
);
    import ipvc_pkg::*;

    ipvc_reg_type prioritySelSerial0Timera;
    ipvc_reg_type prioritySelPwmAdc;
    ipvc_reg_type vectorTableBase;
    ipvc_reg_type fastIrq0Select;

    logic accept;
    logic wrPhase;
    logic rdPhase;
    logic rdReady;
    logic addrValid;
    logic [7:0] addrIdx;
    logic [15:0] statusWord;

    ipvc_field_type srcField [SRC_N];
    logic [SRC_N-1:0] srcEnabled;
    logic [1:0] srcLevel [SRC_N];

    logic found;
    ipvc_vecnum_type winVec;
    logic [1:0] winLevel;
    logic winFast0;
    logic winFast1;
    logic fast0Live;
    logic fast1Live;
    ipvc_addr_type fast0Addr;
    ipvc_addr_type fast1Addr;
    ipvc_addr_type next_vectorAddressBus;
    logic [12:0] baseField;

    // Bus front end.

    assign accept = hsel && hready && htrans[1];
    assign hresp = 1'b0;
    // Reads take one wait state so that hrdata comes from a flip-flop and
    // always reflects a write that finished in the cycle before.
    assign hreadyout = !rdPhase || rdReady;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wrPhase <= 1'b0;
            rdPhase <= 1'b0;
            addrValid <= 1'b0;
            addrIdx <= 8'h00;
        end else if (accept) begin
            wrPhase <= hwrite && (hsize == `IPVC_HSIZE_WORD);
            rdPhase <= !hwrite;
            addrValid <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
            addrIdx <= haddr[9:2];
        end else if (hready) begin
            wrPhase <= 1'b0;
            rdPhase <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdReady <= 1'b0;
        end else if (rdPhase && !rdReady) begin
            rdReady <= 1'b1;
        end else begin
            rdReady <= 1'b0;
        end
    end

    // Register writes; reserved bits are masked off on the way in.

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prioritySelSerial0Timera <= `IPVC_RST_REG; // R2
            prioritySelPwmAdc <= `IPVC_RST_REG; // R2
            vectorTableBase <= `IPVC_RST_REG;
            fastIrq0Select <= `IPVC_RST_REG;
        end else if (wrPhase && addrValid) begin
            unique case (addrIdx)
                `IPVC_IDX_PRI0: begin
                    prioritySelSerial0Timera <= hwdata[15:0] & `IPVC_MASK_PRI0; // R4 R6
                end
                `IPVC_IDX_PRI1: begin
                    prioritySelPwmAdc <= hwdata[15:0] & `IPVC_MASK_PRI1; // R5
                end
                `IPVC_IDX_BASE: begin
                    vectorTableBase <= hwdata[15:0] & `IPVC_MASK_BASE; // R6
                end
                `IPVC_IDX_FAST0: begin
                    fastIrq0Select <= hwdata[15:0] & `IPVC_MASK_FAST0; // R6 R9
                end
                default: begin
                end
            endcase
        end
    end

    // Register reads; unmapped words read as zero.

    assign statusWord = {irqRequest, irqFast, irqLevel, 5'h00, irqVector};

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h00000000;
        end else if (rdPhase && !rdReady) begin
            hrdata <= 32'h00000000;
            if (addrValid) begin
                unique case (addrIdx)
                    `IPVC_IDX_PRI0: hrdata[15:0] <= prioritySelSerial0Timera;
                    `IPVC_IDX_PRI1: hrdata[15:0] <= prioritySelPwmAdc;
                    `IPVC_IDX_BASE: hrdata[15:0] <= vectorTableBase;
                    `IPVC_IDX_FAST0: hrdata[15:0] <= fastIrq0Select;
                    `IPVC_IDX_STAT: hrdata[15:0] <= statusWord;
                    default: hrdata[15:0] <= 16'h0000;
                endcase
            end
        end
    end

    // Field extraction in vector-number order.

    assign srcField[0] = prioritySelSerial0Timera[`IPVC_POS_S0_RX_FULL +: 2]; // R4
    assign srcField[1] = prioritySelSerial0Timera[`IPVC_POS_S0_RX_ERR +: 2];
    assign srcField[2] = prioritySelSerial0Timera[`IPVC_POS_S0_TX_IDLE +: 2];
    assign srcField[3] = prioritySelSerial0Timera[`IPVC_POS_S0_TX_EMPTY +: 2];
    assign srcField[4] = prioritySelSerial0Timera[`IPVC_POS_TA_CH3 +: 2];
    assign srcField[5] = prioritySelSerial0Timera[`IPVC_POS_TA_CH2 +: 2];
    assign srcField[6] = prioritySelSerial0Timera[`IPVC_POS_TA_CH1 +: 2];
    assign srcField[7] = prioritySelPwmAdc[`IPVC_POS_PWMA_FAULT +: 2]; // R5
    assign srcField[8] = prioritySelPwmAdc[`IPVC_POS_PWMB_FAULT +: 2];
    assign srcField[9] = prioritySelPwmAdc[`IPVC_POS_PWMA_RELOAD +: 2];
    assign srcField[10] = prioritySelPwmAdc[`IPVC_POS_PWMB_RELOAD +: 2];
    assign srcField[11] = prioritySelPwmAdc[`IPVC_POS_ADCA_ZC +: 2];
    assign srcField[12] = prioritySelPwmAdc[`IPVC_POS_ADCB_ZC +: 2];
    assign srcField[13] = prioritySelPwmAdc[`IPVC_POS_ADCA_DONE +: 2];
    assign srcField[14] = prioritySelPwmAdc[`IPVC_POS_ADCB_DONE +: 2];

    for (genvar g = 0; g < SRC_N; g++) begin : gen_decode
        ipvc_level_decode u_decode (
            .field(srcField[g]),
            .enabled(srcEnabled[g]),
            .level(srcLevel[g])
        );
    end

    ipvc_vector_select #(
        .SRC_N(SRC_N),
        .VEC_FIRST(VEC_FIRST)
    ) u_select (
        .pending(srcPending),
        .enabled(srcEnabled),
        .level(srcLevel),
        .fastSel0(fastIrq0Select[6:0]),
        .fastSel1(fastIrq1Select),
        .found(found),
        .winVec(winVec),
        .winLevel(winLevel),
        .winFast0(winFast0),
        .winFast1(winFast1),
        .fast0Live(fast0Live),
        .fast1Live(fast1Live)
    );

    // Vector address to the core.

    assign fast0Addr = {fast0VectorHigh, fast0VectorLow}; // R14
    assign fast1Addr = {fast1VectorHigh, fast1VectorLow}; // R14
    assign baseField = vectorTableBase[12:0];

    always_comb begin
        next_vectorAddressBus = 21'h000000;
        if (found && winFast0) begin
            next_vectorAddressBus = fast0Addr; // R10 R13
        end else if (found && winFast1) begin
            next_vectorAddressBus = fast1Addr; // R10
        end else if (found) begin
            next_vectorAddressBus = {baseField, 1'b0, winVec}; // R7 R8
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            vectorAddressBus <= 21'h000000;
        end else begin
            vectorAddressBus <= next_vectorAddressBus;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irqRequest <= 1'b0;
            irqLevel <= 2'h0;
            irqFast <= 1'b0;
            irqVector <= 7'h00;
        end else begin
            irqRequest <= found; // R15
            irqLevel <= winLevel;
            irqFast <= found && (winFast0 || winFast1);
            irqVector <= winVec;
        end
    end

    // Checks.

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    chk_all_off_quiet: assert property ( // R2
        (prioritySelSerial0Timera == 16'h0000 && prioritySelPwmAdc == 16'h0000)
        |=> !irqRequest)
        else $error("request raised while every source is disabled");

    chk_level_top: assert property ( // R1
        (srcPending[0] && srcField[0] == 2'h3) |=> (irqRequest && irqLevel == 2'h2))
        else $error("field 11 did not give a level 2 request");

    chk_level_range: assert property ( // R3
        irqRequest |-> (irqLevel != 2'h3))
        else $error("request level above 2");

    chk_reserved_zero: assert property ( // R6
        (prioritySelSerial0Timera[11:10] == 2'h0) && (vectorTableBase[15:13] == 3'h0)
        && (fastIrq0Select[15:7] == 9'h000))
        else $error("reserved bit holds a one");

    chk_base_upper: assert property ( // R7
        (found && !winFast0 && !winFast1)
        |=> (vectorAddressBus[20:8] == $past(baseField)))
        else $error("vector base not in the upper address bits");

    chk_low_single: assert property ( // R8
        (srcPending == 15'h0001 && srcField[0] != 2'h0 && fastIrq0Select[6:0] != VEC_FIRST
        && fastIrq1Select != VEC_FIRST)
        |=> (vectorAddressBus[7:0] == {1'b0, VEC_FIRST}))
        else $error("lower address bits do not name the lone source");

    chk_fast_bypass: assert property ( // R10
        (found && winFast0) |=> (irqFast && vectorAddressBus == $past(fast0Addr)))
        else $error("fast 0 address not driven");

    chk_fast_over_l2: assert property ( // R12
        (srcPending[0] && srcPending[SRC_N-1] && srcField[0] == 2'h3
        && srcField[SRC_N-1] == 2'h3 && fastIrq0Select[6:0] == VEC_FIRST + 7'(SRC_N-1))
        |=> (irqFast && irqVector == VEC_FIRST + 7'(SRC_N-1)))
        else $error("fast source lost to a lower-numbered level 2 source");

    chk_fast0_first: assert property ( // R13
        (fast0Live && fast1Live) |=> (vectorAddressBus == $past(fast0Addr)))
        else $error("fast 1 served ahead of fast 0");

    chk_tie_lower: assert property ( // R15
        (srcPending == 15'h0006 && srcField[1] == srcField[2] && srcField[1] != 2'h0
        && !fast0Live && !fast1Live)
        |=> (irqVector == VEC_FIRST + 7'h01))
        else $error("tie not broken toward the lower vector number");

    chk_read_wait: assert property (
        (rdPhase && !rdReady) |-> (!hreadyout ##1 hreadyout))
        else $error("read data phase did not take exactly one wait state");

    // Codes 01 and 10 of a lone pending source give levels 0 and 1.
    chk_level_low: assert property ( // R1
        (srcPending == 15'h0001 && srcField[0] == 2'h1) |=> (irqRequest && irqLevel == 2'h0))
        else $error("field 01 did not give a level 0 request");

    chk_level_mid: assert property ( // R1
        (srcPending == 15'h0001 && srcField[0] == 2'h2) |=> (irqRequest && irqLevel == 2'h1))
        else $error("field 10 did not give a level 1 request");

    // A pending source whose field is 00 must stay silent.
    chk_off_silent: assert property ( // R15
        (srcPending == 15'h0001 && srcField[0] == 2'h0) |=> !irqRequest)
        else $error("disabled source raised a request");

    chk_idle_zero: assert property ( // R15
        !found |=> (!irqRequest && vectorAddressBus == 21'h000000))
        else $error("vector output not cleared with no winner");

    chk_fast1_bypass: assert property ( // R10
        (found && winFast1) |=> (irqFast && vectorAddressBus == $past(fast1Addr)))
        else $error("fast 1 address not driven");

    // The two fast address halves must land at their own positions on the bus.
    chk_fast_halves: assert property ( // R14
        (found && winFast0)
        |=> (vectorAddressBus[20:16] == $past(fast0VectorHigh)
        && vectorAddressBus[15:0] == $past(fast0VectorLow)))
        else $error("fast 0 address halves misplaced");

    // A word write lands one edge later with its reserved bits cleared.
    chk_write_masked: assert property ( // R4 R6
        (wrPhase && addrValid && addrIdx == `IPVC_IDX_PRI0)
        |=> (prioritySelSerial0Timera == ($past(hwdata[15:0]) & `IPVC_MASK_PRI0)))
        else $error("priority write did not land masked");

    // A selection only becomes fast when its source sits at level 2.
    chk_fast0_top: assert property ( // R9
        (found && winFast0) |-> (winLevel == `IPVC_LVL_TOP))
        else $error("fast 0 taken below level 2");

    chk_fast1_top: assert property ( // R12
        (found && winFast1) |-> (winLevel == `IPVC_LVL_TOP))
        else $error("fast 1 taken below level 2");

    // The status word read back must match the core outputs at the capture edge.
    chk_read_status: assert property (
        (rdPhase && !rdReady && addrValid && addrIdx == `IPVC_IDX_STAT)
        |=> (hrdata == {16'h0000, $past(statusWord)}))
        else $error("status read does not match the core outputs");

    cov_fast0_win: cover property (found && winFast0);
    cov_fast1_win: cover property (found && winFast1);
    cov_table_win: cover property (found && !winFast0 && !winFast1 && winLevel == 2'h1);
    cov_status_read: cover property (rdReady && addrIdx == `IPVC_IDX_STAT);
    cov_fast_both: cover property (fast0Live && fast1Live);
endmodule

// >>> ipvc_core_model.sv
// Behavioural processor core that takes vector addresses from the block.
// Assumes the block's core outputs are registered on ref_clk.
`timescale 1ns/1ps
module ipvc_core_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // From the block
    input wire logic irqRequest,
    input wire logic irqFast,
    input wire ipvc_pkg::ipvc_addr_type vectorAddressBus,
    // Last vector taken
    output ipvc_pkg::ipvc_addr_type takenAddr,
    output logic takenFast
);
    import ipvc_pkg::*;

    // There is no acknowledge, so the core takes whatever stands while a request is high.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            takenAddr <= 21'h000000;
            takenFast <= 1'b0;
        end else if (irqRequest) begin
            takenAddr <= vectorAddressBus;
            takenFast <= irqFast;
        end
    end
endmodule

// >>> irq_priority_vector_config_tb.sv
// Self-checking testbench for the priority and vector configuration block.
// Assumes a single AHB-Lite slave, so the bus hready is the slave's hreadyout.
`timescale 1ns/1ps
module irq_priority_vector_config_tb;
    import ipvc_pkg::*;

    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [14:0] srcPending = 15'h0000;
    ipvc_vecnum_type fastIrq1Select = 7'h00;
    logic [15:0] fast0VectorLow = 16'hA5C3;
    logic [4:0] fast0VectorHigh = 5'h15;
    logic [15:0] fast1VectorLow = 16'h3C5A;
    logic [4:0] fast1VectorHigh = 5'h0A;
    logic irqRequest;
    logic [1:0] irqLevel;
    logic irqFast;
    ipvc_vecnum_type irqVector;
    ipvc_addr_type vectorAddressBus;
    ipvc_addr_type takenAddr;
    logic takenFast;
    int errTotal = 0;
    int checked = 0;
    logic [12:0] base = 13'h0ABC;

    assign hready = hreadyout;

    ipvc_config i_dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .srcPending(srcPending),
        .fastIrq1Select(fastIrq1Select), .fast0VectorLow(fast0VectorLow),
        .fast0VectorHigh(fast0VectorHigh), .fast1VectorLow(fast1VectorLow),
        .fast1VectorHigh(fast1VectorHigh), .irqRequest(irqRequest), .irqLevel(irqLevel),
        .irqFast(irqFast), .irqVector(irqVector), .vectorAddressBus(vectorAddressBus));

    ipvc_core_model i_core (.ref_clk(ref_clk), .nrst(nrst), .irqRequest(irqRequest),
        .irqFast(irqFast), .vectorAddressBus(vectorAddressBus), .takenAddr(takenAddr),
        .takenFast(takenFast));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Returns at the rising edge where hready is sampled high.
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 20) begin
                errTotal++;
                $display("MISMATCH at %0t: bus wait ran out", $time);
                stop_test();
            end
            @(posedge ref_clk);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata);
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wr ? wdata : 32'hDEAD0000;
        wait_ready();
        rdata = hrdata;
    endtask

    task automatic wr(input logic [31:0] addr, input logic [15:0] data);
        logic [31:0] unused;
        bus(1'b1, addr, {16'h0000, data}, unused);
    endtask

    task automatic rd_chk(input logic [31:0] addr, input logic [15:0] exp);
        logic [31:0] rdata;
        bus(1'b0, addr, 32'h00000000, rdata);
        chk(rdata, {16'h0000, exp});
    endtask

    // Lets the core outputs and the core model settle after the last change.
    task automatic settle();
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic expect_core(input logic [1:0] lvl, input logic fast,
        input logic [6:0] vec, input logic [20:0] addr);
        chk({irqRequest, irqFast, irqLevel, irqVector}, {1'b1, fast, lvl, vec});
        chk(vectorAddressBus, addr);
        chk({takenFast, takenAddr}, {fast, addr});
    endtask

    function automatic logic [20:0] table_addr(input logic [6:0] vec);
        return {base, 1'b0, vec};
    endfunction

    function automatic int field_pos(input int i);
        if (i < 2) return 14 - 2 * i;
        if (i < 7) return 8 - 2 * (i - 2);
        return 14 - 2 * (i - 7);
    endfunction

    initial begin
        logic [15:0] val;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rd_chk(32'h20, 16'h0000);
        rd_chk(32'h24, 16'h0000);
        rd_chk(32'h28, 16'h0000);
        rd_chk(32'h2C, 16'h0000);
        chk({irqRequest, vectorAddressBus}, 22'h000000);
        $display("Reset values test done");

        wr(32'h20, 16'hFFFF);
        rd_chk(32'h20, 16'hF3FF);
        wr(32'h24, 16'hFFFF);
        rd_chk(32'h24, 16'hFFFF);
        wr(32'h28, 16'hFFFF);
        rd_chk(32'h28, 16'h1FFF);
        wr(32'h2C, 16'hFFFF);
        rd_chk(32'h2C, 16'h007F);
        wr(32'h30, 16'h1234);
        rd_chk(32'h30, 16'h0000);
        $display("Reserved bits test done");

        wr(32'h20, 16'h0000);
        wr(32'h24, 16'h0000);
        wr(32'h2C, 16'h0000);
        wr(32'h28, {3'h7, base});
        for (int i = 0; i < 15; i++) begin
            for (int c = 0; c < 4; c++) begin
                val = 16'(c) << field_pos(i);
                wr(i < 7 ? 32'h20 : 32'h24, val);
                rd_chk(i < 7 ? 32'h20 : 32'h24, val);
                srcPending <= 15'h0001 << i;
                settle();
                if (c == 0) begin
                    chk({irqRequest, vectorAddressBus}, 22'h000000);
                end else begin
                    expect_core(2'(c - 1), 1'b0, 7'h40 + 7'(i),
                        table_addr(7'h40 + 7'(i)));
                end
            end
        end
        $display("Field decode test done");

        wr(32'h24, 16'h0000);
        wr(32'h20, 16'hB300);
        srcPending <= 15'h0007;
        settle();
        expect_core(2'h2, 1'b0, 7'h41, table_addr(7'h41));
        srcPending <= 15'h0005;
        settle();
        expect_core(2'h2, 1'b0, 7'h42, table_addr(7'h42));
        srcPending <= 15'h0006;
        settle();
        expect_core(2'h2, 1'b0, 7'h41, table_addr(7'h41));
        $display("Ranking test done");

        // Both fast sources are set to level 2, as software must.
        wr(32'h20, 16'hC000);
        wr(32'h24, 16'h000F);
        wr(32'h2C, 16'h004E);
        rd_chk(32'h2C, 16'h004E);
        fastIrq1Select <= 7'h4D;
        srcPending <= 15'h6001;
        settle();
        expect_core(2'h2, 1'b1, 7'h4E, {fast0VectorHigh, fast0VectorLow});
        rd_chk(32'h80, 16'hE04E);
        srcPending <= 15'h2001;
        settle();
        expect_core(2'h2, 1'b1, 7'h4D, {fast1VectorHigh, fast1VectorLow});
        srcPending <= 15'h0001;
        settle();
        expect_core(2'h2, 1'b0, 7'h40, table_addr(7'h40));
        $display("Fast interrupt test done");
        stop_test();
    end
endmodule
